// ---- nba_core.v ----
// nibble alu core: accumulator, flags, op port and wishbone registers
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "nba_map.vh"
module nba_core #(
    parameter WIDTH = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire op_valid_i,
    input wire [3:0] op_code_i,
    input wire [WIDTH-1:0] op_data_i,
    output wire op_ready_o,
    input wire irq_accept_i,
    input wire interrupt_return_op_i,
    input wire [3:0] restore_flags_i,
    output reg [3:0] saved_flags_o,
    output reg saved_valid_o,
    input wire branch_i,
    output reg branch_taken_o,
    output reg [WIDTH-1:0] store_data_o,
    output reg store_zero_o,
    output reg store_valid_o,
    output wire [WIDTH-1:0] acc_o,
    output wire [3:0] flags_o
);
    reg [WIDTH-1:0] acc;
    reg carry_flag;
    reg zero_flag;
    reg branch_condition_flag;
    reg general_flag;
    reg [WIDTH-1:0] last_result;
    reg last_carry;
    reg last_zero;
    reg [WIDTH-1:0] next_acc;
    reg next_carry_flag;
    reg next_zero_flag;
    reg next_branch_condition_flag;
    reg next_general_flag;
    reg [2:0] alu_mode;
    reg [3:0] ex_code;
    reg [WIDTH-1:0] ex_data;
    reg ex_valid;
    wire bus_req;
    wire bus_wr;
    wire cmd_wr;
    wire acc_wr;
    wire flags_wr;
    wire [WIDTH-1:0] alu_result;
    wire alu_carry;
    wire alu_zero;
    wire acc_zero;
    wire [WIDTH-1:0] cmd_data;
    wire [3:0] cmd_code;
    wire [3:0] reg_sel;
    wire store_take;
    reg alu_cin;

    localparam SEL_ACC = 0;
    localparam SEL_FLAGS = 1;
    localparam SEL_CMD = 2;
    localparam SEL_STATUS = 3;

    // one-hot register decode, shared by write strobes and read mux
    function [3:0] reg_decode;
        input [3:0] adr;
        begin
            reg_decode = 4'b0000;
            if (adr == `NBA_ADR_ACC) begin
                reg_decode[SEL_ACC] = 1'b1;
            end else if (adr == `NBA_ADR_FLAGS) begin
                reg_decode[SEL_FLAGS] = 1'b1;
            end else if (adr == `NBA_ADR_CMD) begin
                reg_decode[SEL_CMD] = 1'b1;
            end else if (adr == `NBA_ADR_STATUS) begin
                reg_decode[SEL_STATUS] = 1'b1;
            end
        end
    endfunction

    assign reg_sel = reg_decode(wb_adr_i);
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    assign cmd_wr = bus_wr & reg_sel[SEL_CMD];
    assign acc_wr = bus_wr & reg_sel[SEL_ACC];
    assign flags_wr = bus_wr & reg_sel[SEL_FLAGS];
    assign store_take = ex_valid & (ex_code == `NBA_OP_STORE);
    assign cmd_code = wb_dat_i[`NBA_CMD_CODE_LSB +: 4];
    assign cmd_data = wb_dat_i[`NBA_CMD_DATA_LSB +: WIDTH];
    // bus command, interrupt and return steal the op port for a cycle
    assign op_ready_o = ~(cmd_wr | irq_accept_i | interrupt_return_op_i);
    assign acc_o = acc;
    assign flags_o = {general_flag, branch_condition_flag, zero_flag,
        carry_flag};

    // pick the operation for this cycle
    always @* begin
        ex_valid = 1'b0;
        ex_code = `NBA_OP_STORE;
        ex_data = {WIDTH{1'b0}};
        if (cmd_wr & ~irq_accept_i & ~interrupt_return_op_i) begin
            ex_valid = 1'b1;
            ex_code = cmd_code;
            ex_data = cmd_data;
        end else if (op_valid_i & op_ready_o) begin
            ex_valid = 1'b1;
            ex_code = op_code_i;
            ex_data = op_data_i;
        end
    end

    always @* begin
        case (ex_code)
            `NBA_OP_ADD: alu_mode = `NBA_ALU_ADD;
            `NBA_OP_ADD_WITH_CARRY_OP: alu_mode = `NBA_ALU_ADD;
            `NBA_OP_REVERSE_SUBTRACT_WITH_CARRY_OP: alu_mode = `NBA_ALU_RSUB;
            `NBA_OP_COMPARE_OP: alu_mode = `NBA_ALU_RSUB;
            `NBA_OP_AND: alu_mode = `NBA_ALU_AND;
            `NBA_OP_OR: alu_mode = `NBA_ALU_OR;
            `NBA_OP_XOR: alu_mode = `NBA_ALU_XOR;
            `NBA_OP_ROTATE_LEFT_THROUGH_CARRY_OP: alu_mode = `NBA_ALU_ROL;
            `NBA_OP_ROTATE_RIGHT_THROUGH_CARRY_OP: alu_mode = `NBA_ALU_ROR;
            default: alu_mode = `NBA_ALU_PASS;
        endcase
    end

    // carry in: carry flag for carry ops, one for plain compare
    always @* begin
        case (ex_code)
            `NBA_OP_ADD: alu_cin = 1'b0;
            `NBA_OP_COMPARE_OP: alu_cin = 1'b1;
            default: alu_cin = carry_flag;
        endcase
    end

    nba_alu #(.WIDTH(WIDTH)) u_alu (
        .a_i(acc),
        .b_i(ex_data),
        .cin_i(alu_cin),
        .mode_i(alu_mode),
        .result_o(alu_result),
        .carry_o(alu_carry),
        .zero_o(alu_zero)
    );

    nba_zero #(.WIDTH(WIDTH)) u_store_zero (
        .value_i(acc),
        .zero_o(acc_zero)
    );

    // next state of accumulator and flags
    always @* begin
        next_acc = acc;
        next_carry_flag = carry_flag;
        next_zero_flag = zero_flag;
        next_branch_condition_flag = branch_condition_flag;
        next_general_flag = general_flag;
        if (interrupt_return_op_i) begin
            next_carry_flag = restore_flags_i[`NBA_FLD_CF];
            next_zero_flag = restore_flags_i[`NBA_FLD_ZF];
            next_branch_condition_flag = restore_flags_i[`NBA_FLD_SF];
            next_general_flag = restore_flags_i[`NBA_FLD_GF];
        end else if (ex_valid) begin
            next_branch_condition_flag = 1'b1;
            case (ex_code)
                `NBA_OP_STORE: begin
                    next_branch_condition_flag = 1'b1;
                end
                `NBA_OP_LOAD: begin
                    next_acc = alu_result;
                    next_zero_flag = alu_zero;
                end
                `NBA_OP_ADD: begin
                    next_acc = alu_result;
                    next_zero_flag = alu_zero;
                    next_branch_condition_flag = ~alu_carry;
                end
                `NBA_OP_ADD_WITH_CARRY_OP: begin
                    next_acc = alu_result;
                    next_carry_flag = alu_carry;
                    next_zero_flag = alu_zero;
                    next_branch_condition_flag = ~alu_carry;
                end
                `NBA_OP_REVERSE_SUBTRACT_WITH_CARRY_OP: begin
                    next_acc = alu_result;
                    next_carry_flag = alu_carry;
                    next_zero_flag = alu_zero;
                    next_branch_condition_flag = alu_carry;
                end
                `NBA_OP_COMPARE_OP: begin
                    next_carry_flag = alu_carry;
                    next_zero_flag = alu_zero;
                    next_branch_condition_flag = ~alu_zero;
                end
                `NBA_OP_AND, `NBA_OP_OR, `NBA_OP_XOR: begin
                    next_acc = alu_result;
                    next_zero_flag = alu_zero;
                end
                `NBA_OP_ROTATE_LEFT_THROUGH_CARRY_OP, `NBA_OP_ROTATE_RIGHT_THROUGH_CARRY_OP: begin
                    next_acc = alu_result;
                    next_carry_flag = alu_carry;
                    next_zero_flag = alu_zero;
                    next_branch_condition_flag = ~alu_carry;
                end
                `NBA_OP_TEST_AND_PRESET_OP: begin
                    next_branch_condition_flag = carry_flag;
                    next_carry_flag = 1'b1;
                end
                `NBA_OP_TESTCF: begin
                    next_branch_condition_flag = ~carry_flag;
                    next_carry_flag = 1'b0;
                end
                `NBA_OP_GFSET: next_general_flag = 1'b1;
                `NBA_OP_GFCLR: next_general_flag = 1'b0;
                default: begin
                    next_branch_condition_flag = ~general_flag;
                end
            endcase
        end else if (acc_wr) begin
            next_acc = wb_dat_i[WIDTH-1:0];
        end else if (flags_wr) begin
            next_carry_flag = wb_dat_i[`NBA_FLD_CF];
            next_zero_flag = wb_dat_i[`NBA_FLD_ZF];
            next_branch_condition_flag = wb_dat_i[`NBA_FLD_SF];
            next_general_flag = wb_dat_i[`NBA_FLD_GF];
        end
    end

    // flags other than branch condition carry no reset and hold through it
    always @(posedge clk_i) begin
        if (!rst_i) begin
            carry_flag <= next_carry_flag;
            zero_flag <= next_zero_flag;
            general_flag <= next_general_flag;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            branch_condition_flag <= `NBA_RST_SF;
            acc <= `NBA_RST_ACC;
        end else begin
            branch_condition_flag <= next_branch_condition_flag;
            acc <= next_acc;
        end
    end

    // flag snapshot for the stack on interrupt accept
    always @(posedge clk_i) begin
        if (rst_i) begin
            saved_flags_o <= 4'h0;
            saved_valid_o <= 1'b0;
        end else begin
            saved_valid_o <= irq_accept_i & ~interrupt_return_op_i;
            if (irq_accept_i & ~interrupt_return_op_i) begin
                saved_flags_o <= flags_o;
            end
        end
    end

    // branch decided on the flag value before this cycle's op
    always @(posedge clk_i) begin
        if (rst_i) begin
            branch_taken_o <= 1'b0;
        end else begin
            branch_taken_o <= branch_i & branch_condition_flag;
        end
    end

    // accumulator copy and its zero test for a store
    always @(posedge clk_i) begin
        if (rst_i) begin
            store_data_o <= {WIDTH{1'b0}};
            store_zero_o <= 1'b0;
            store_valid_o <= 1'b0;
        end else begin
            store_valid_o <= store_take;
            if (store_take) begin
                store_data_o <= acc;
                store_zero_o <= acc_zero;
            end
        end
    end

    // last alu outcome for the status register
    always @(posedge clk_i) begin
        if (rst_i) begin
            last_result <= {WIDTH{1'b0}};
            last_carry <= 1'b0;
            last_zero <= 1'b0;
        end else if (ex_valid & ~interrupt_return_op_i) begin
            last_result <= alu_result;
            last_carry <= alu_carry;
            last_zero <= alu_zero;
        end
    end

    // wishbone slave, one wait cycle, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req & ~wb_we_i) begin
                if (reg_sel[SEL_ACC]) begin
                    wb_dat_o[WIDTH-1:0] <= acc;
                end else if (reg_sel[SEL_FLAGS]) begin
                    wb_dat_o[3:0] <= flags_o;
                end else if (reg_sel[SEL_STATUS]) begin
                    wb_dat_o[WIDTH+1:0] <= {last_zero, last_carry,
                        last_result};
                end
            end
        end
    end
endmodule // nba_core

// ---- nba_map.vh ----
// register offsets, field positions, op codes and reset values
`ifndef NBA_MAP_VH
`define NBA_MAP_VH
`define NBA_ADR_ACC 4'h0
`define NBA_ADR_FLAGS 4'h4
`define NBA_ADR_CMD 4'h8
`define NBA_ADR_STATUS 4'hC
`define NBA_FLD_CF 0
`define NBA_FLD_ZF 1
`define NBA_FLD_SF 2
`define NBA_FLD_GF 3
`define NBA_CMD_CODE_LSB 0
`define NBA_CMD_DATA_LSB 4
`define NBA_RST_ACC 4'h0
`define NBA_RST_SF 1'b1
`define NBA_OP_STORE 4'h0
`define NBA_OP_LOAD 4'h1
`define NBA_OP_ADD 4'h2
`define NBA_OP_ADD_WITH_CARRY_OP 4'h3
`define NBA_OP_REVERSE_SUBTRACT_WITH_CARRY_OP 4'h4
`define NBA_OP_COMPARE_OP 4'h5
`define NBA_OP_AND 4'h6
`define NBA_OP_OR 4'h7
`define NBA_OP_XOR 4'h8
`define NBA_OP_ROTATE_LEFT_THROUGH_CARRY_OP 4'h9
`define NBA_OP_ROTATE_RIGHT_THROUGH_CARRY_OP 4'hA
`define NBA_OP_TEST_AND_PRESET_OP 4'hB
`define NBA_OP_TESTCF 4'hC
`define NBA_OP_GFSET 4'hD
`define NBA_OP_GFCLR 4'hE
`define NBA_OP_GFTEST 4'hF
`define NBA_ALU_ADD 3'h0
`define NBA_ALU_RSUB 3'h1
`define NBA_ALU_ROL 3'h2
`define NBA_ALU_ROR 3'h3
`define NBA_ALU_AND 3'h4
`define NBA_ALU_OR 3'h5
`define NBA_ALU_XOR 3'h6
`define NBA_ALU_PASS 3'h7
`endif

// ---- nba_zero.v ----
// zero detect for one nibble
`timescale 1ns/1ps
module nba_zero #(
    parameter WIDTH = 4
) (
    input wire [WIDTH-1:0] value_i,
    output wire zero_o
);
    assign zero_o = ~|value_i;
endmodule // nba_zero

// ---- nba_alu.v ----
// combinational nibble alu with carry and zero indications
`timescale 1ns/1ps
`include "nba_map.vh"
module nba_alu #(
    parameter WIDTH = 4
) (
    input wire [WIDTH-1:0] a_i,
    input wire [WIDTH-1:0] b_i,
    input wire cin_i,
    input wire [2:0] mode_i,
    output reg [WIDTH-1:0] result_o,
    output reg carry_o,
    output wire zero_o
);
    wire [WIDTH:0] add_sum;
    wire [WIDTH:0] rsub_sum;
    assign add_sum = {1'b0, a_i} + {1'b0, b_i} + {{WIDTH{1'b0}}, cin_i};
    // b minus a as b plus inverted a plus carry
    assign rsub_sum = {1'b0, b_i} + {1'b0, ~a_i} + {{WIDTH{1'b0}}, cin_i};
    always @* begin
        result_o = a_i;
        carry_o = cin_i;
        case (mode_i)
            `NBA_ALU_ADD: begin
                {carry_o, result_o} = add_sum;
            end
            `NBA_ALU_RSUB: begin
                {carry_o, result_o} = rsub_sum;
            end
            `NBA_ALU_ROL: begin
                result_o = {a_i[WIDTH-2:0], cin_i};
                carry_o = a_i[WIDTH-1];
            end
            `NBA_ALU_ROR: begin
                result_o = {cin_i, a_i[WIDTH-1:1]};
                carry_o = a_i[0];
            end
            `NBA_ALU_AND: result_o = a_i & b_i;
            `NBA_ALU_OR: result_o = a_i | b_i;
            `NBA_ALU_XOR: result_o = a_i ^ b_i;
            default: result_o = b_i;
        endcase
    end
    nba_zero #(.WIDTH(WIDTH)) u_zero (
        .value_i(result_o),
        .zero_o(zero_o)
    );
endmodule // nba_alu

// ---- nba_core_props.sv ----
// concurrent checks on the nibble alu core ports
`timescale 1ns/1ps
`include "nba_map.vh"
module nba_core_props #(
    parameter WIDTH = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire op_valid_i,
    input wire op_ready_o,
    input wire [3:0] op_code_i,
    input wire irq_accept_i,
    input wire interrupt_return_op_i,
    input wire [3:0] restore_flags_i,
    input wire [3:0] saved_flags_o,
    input wire saved_valid_o,
    input wire branch_i,
    input wire branch_taken_o,
    input wire [WIDTH-1:0] store_data_o,
    input wire store_zero_o,
    input wire store_valid_o,
    input wire [WIDTH-1:0] acc_o,
    input wire [3:0] flags_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire op_take = op_valid_i && op_ready_o;
    property p_branch; branch_i |=> branch_taken_o == $past(flags_o[2]);
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch outcome wrong");
    property p_save;
        irq_accept_i && !interrupt_return_op_i |=>
        saved_valid_o && saved_flags_o == $past(flags_o);
    endproperty
    a_save: assert property (p_save)
        else $error("flag snapshot wrong");
    property p_interrupt_return_op; interrupt_return_op_i |=> flags_o == $past(restore_flags_i);
    endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op)
        else $error("flag restore wrong");
    property p_reset;
        disable iff (1'b0) rst_i |=> flags_o[2] && acc_o == 0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");
    property p_test_and_preset_op; op_take && op_code_i == `NBA_OP_TEST_AND_PRESET_OP |=>
        flags_o[0] && flags_o[2] == $past(flags_o[0]); endproperty
    a_test_and_preset_op: assert property (p_test_and_preset_op)
        else $error("test and preset wrong");
    property p_testcf; op_take && op_code_i == `NBA_OP_TESTCF |=>
        !flags_o[0] && flags_o[2] == !$past(flags_o[0]); endproperty
    a_testcf: assert property (p_testcf)
        else $error("carry test wrong");
    property p_rotate_left_through_carry_op; op_take && op_code_i == `NBA_OP_ROTATE_LEFT_THROUGH_CARRY_OP |=>
        acc_o == {$past(acc_o[WIDTH-2:0]), $past(flags_o[0])}
        && flags_o[0] == $past(acc_o[WIDTH-1]); endproperty
    a_rotate_left_through_carry_op: assert property (p_rotate_left_through_carry_op)
        else $error("rotate left wrong");
    property p_rotate_right_through_carry_op; op_take && op_code_i == `NBA_OP_ROTATE_RIGHT_THROUGH_CARRY_OP |=>
        acc_o == {$past(flags_o[0]), $past(acc_o[WIDTH-1:1])}
        && flags_o[0] == $past(acc_o[0]); endproperty
    a_rotate_right_through_carry_op: assert property (p_rotate_right_through_carry_op)
        else $error("rotate right wrong");
    property p_store; op_take && op_code_i == `NBA_OP_STORE |=>
        store_valid_o && store_data_o == $past(acc_o)
        && store_zero_o == ($past(acc_o) == 0); endproperty
    a_store: assert property (p_store)
        else $error("store output wrong");
    property p_gf; op_take && op_code_i < `NBA_OP_GFSET |=>
        $stable(flags_o[3]); endproperty
    a_gf: assert property (p_gf)
        else $error("general flag moved");
    property p_refuse; irq_accept_i || interrupt_return_op_i |-> !op_ready_o; endproperty
    a_refuse: assert property (p_refuse)
        else $error("op port not held off");
endmodule // nba_core_props
bind nba_core nba_core_props #(.WIDTH(WIDTH)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
    .op_ready_o(op_ready_o), .op_code_i(op_code_i),
    .irq_accept_i(irq_accept_i), .interrupt_return_op_i(interrupt_return_op_i),
    .restore_flags_i(restore_flags_i), .saved_flags_o(saved_flags_o),
    .saved_valid_o(saved_valid_o), .branch_i(branch_i),
    .branch_taken_o(branch_taken_o), .store_data_o(store_data_o),
    .store_zero_o(store_zero_o), .store_valid_o(store_valid_o),
    .acc_o(acc_o), .flags_o(flags_o)
);

// ---- nba_core_tb_top.sv ----
// self-checking bench for the nibble alu core
`timescale 1ns/1ps
module nba_core_tb_top;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic op_valid = 0, irq = 0, interrupt_return_op = 0, br = 0;
    logic [3:0] adr = 0, sel = 4'hF, op_code = 0, op_data = 0, rfl = 0;
    logic [31:0] dat = 0, q, wb_dat_o;
    logic wb_ack_o, op_ready_o, saved_valid_o, branch_taken_o;
    logic store_zero_o, store_valid_o;
    logic [3:0] saved_flags_o, store_data_o, acc_o, flags_o;
    int error_cnt = 0, num_checks = 0, cyc_cnt = 0;
    nba_core #(.WIDTH(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_valid_i(op_valid),
        .op_code_i(op_code), .op_data_i(op_data), .op_ready_o(op_ready_o),
        .irq_accept_i(irq), .interrupt_return_op_i(interrupt_return_op), .restore_flags_i(rfl),
        .saved_flags_o(saved_flags_o), .saved_valid_o(saved_valid_o),
        .branch_i(br), .branch_taken_o(branch_taken_o),
        .store_data_o(store_data_o), .store_zero_o(store_zero_o),
        .store_valid_o(store_valid_o), .acc_o(acc_o), .flags_o(flags_o)
    );
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            print_verdict;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks++;
            if (got !== exp) begin
                error_cnt++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wb(input logic w, input [3:0] a, input [31:0] d);
        begin
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1) begin
                @(posedge clk_i);
            end
            q = wb_dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // one-cycle strobe of {op_valid, branch, interrupt_return_op, irq}
    task pulse(input [3:0] m);
        begin
            {op_valid, br, interrupt_return_op, irq} <= m;
            @(posedge clk_i);
            {op_valid, br, interrupt_return_op, irq} <= 4'h0;
            @(posedge clk_i);
        end
    endtask
    task t(input [3:0] c, d, a0, f0, ea, ef);
        begin
            wb(1'b1, 4'h0, {28'h000_0000, a0});
            wb(1'b1, 4'h4, {28'h000_0000, f0});
            op_code <= c;
            op_data <= d;
            pulse(4'h8);
            chk(acc_o, ea);
            chk(flags_o, ef);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(flags_o[2], 1'b1);
        t(4'h3, 4'h5, 4'hC, 4'h5, 4'h2, 4'h1);
        t(4'h3, 4'hF, 4'h1, 4'h0, 4'h0, 4'h3);
        t(4'h4, 4'h5, 4'hC, 4'h5, 4'h9, 4'h0);
        t(4'h4, 4'h8, 4'h1, 4'h1, 4'h7, 4'h5);
        t(4'h4, 4'h2, 4'h2, 4'h1, 4'h0, 4'h7);
        t(4'h4, 4'h5, 4'h8, 4'h1, 4'hD, 4'h0);
        t(4'h5, 4'h5, 4'hC, 4'h5, 4'hC, 4'h4);
        t(4'h6, 4'h5, 4'hC, 4'h1, 4'h4, 4'h5);
        t(4'h2, 4'h9, 4'h7, 4'h4, 4'h0, 4'h2);
        t(4'h2, 4'h9, 4'h9, 4'h4, 4'h2, 4'h0);
        t(4'h2, 4'h2, 4'h4, 4'h1, 4'h6, 4'h5);
        t(4'h9, 4'h0, 4'hB, 4'h5, 4'h7, 4'h1);
        t(4'h9, 4'h0, 4'h8, 4'h4, 4'h0, 4'h3);
        t(4'hA, 4'h0, 4'h9, 4'h4, 4'h4, 4'h1);
        t(4'hA, 4'h0, 4'h6, 4'h5, 4'hB, 4'h4);
        t(4'hB, 4'h0, 4'h3, 4'h1, 4'h3, 4'h5);
        t(4'hB, 4'h0, 4'h3, 4'h6, 4'h3, 4'h3);
        t(4'hC, 4'h0, 4'h3, 4'h5, 4'h3, 4'h0);
        t(4'hC, 4'h0, 4'h3, 4'h2, 4'h3, 4'h6);
        t(4'hD, 4'h0, 4'h3, 4'h0, 4'h3, 4'hC);
        t(4'hE, 4'h0, 4'h3, 4'hB, 4'h3, 4'h7);
        t(4'hF, 4'h0, 4'h3, 4'h8, 4'h3, 4'h8);
        t(4'h8, 4'hF, 4'hF, 4'h1, 4'h0, 4'h7);
        t(4'h7, 4'h0, 4'h0, 4'h0, 4'h0, 4'h6);
        t(4'h1, 4'h0, 4'h9, 4'h1, 4'h0, 4'h7);
        t(4'h0, 4'h0, 4'h0, 4'h9, 4'h0, 4'hD);
        chk({store_valid_o, store_zero_o, store_data_o}, 6'h30);
        $display("op table done");
        wb(1'b1, 4'h0, 32'h0000_0007);
        wb(1'b1, 4'h4, 32'h0000_000B);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({acc_o, flags_o}, 8'h0F);
        $display("mid-run reset done");
        wb(1'b1, 4'h0, 32'h0000_0009);
        wb(1'b1, 4'h8, 32'h0000_0072);
        chk(acc_o, 4'h0);
        wb(1'b0, 4'hC, 32'h0000_0000);
        chk(q, 32'h0000_0030);
        wb(1'b0, 4'h4, 32'h0000_0000);
        chk(q, 32'h0000_000B);
        wb(1'b0, 4'h2, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        $display("register bus done");
        wb(1'b1, 4'h4, 32'h0000_000A);
        op_code <= 4'h1;
        op_data <= 4'hF;
        pulse(4'h9);
        chk({saved_valid_o, saved_flags_o, acc_o}, 9'h1A0);
        rfl <= 4'h5;
        pulse(4'h2);
        chk(flags_o, 4'h5);
        $display("interrupt save and restore done");
        pulse(4'h4);
        chk(branch_taken_o, 1'b1);
        wb(1'b1, 4'h4, 32'h0000_0000);
        pulse(4'h4);
        chk(branch_taken_o, 1'b0);
        $display("branch done");
        print_verdict;
    end
endmodule // nba_core_tb_top
